// ### inc/crb_pkg.sv
// Constants, types and register map of the clock, reset and boot sequencer
package crb_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_PLL_CFG = 8'h00;
  localparam logic [7:0] ADDR_PLL_CTL = 8'h04;
  localparam logic [7:0] ADDR_SW_RESET = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Configuration register fields
  localparam int CFG_MULT_LSB = 0;
  localparam int CFG_MULT_W = 7;
  localparam int CFG_DIV_BIT = 7;

  // Control register fields
  localparam int CTL_PD_BIT = 0;
  localparam int CTL_STOP_CLOCK_BIT_BIT = 1;
  localparam int CTL_STALL_BIT = 2;
  localparam int CTL_RATIO_BIT = 3;

  // Software reset and status fields
  localparam int SWR_BIT = 0;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_VALID_BIT = 3;
  localparam int STAT_LP_LSB = 4;
  localparam int STAT_RUN_BIT = 6;
  localparam int STAT_BYPASS_BIT = 7;

  // Reset values
  localparam logic [6:0] MULT_RST = 7'h08;
  localparam logic DIV_RST = 1'b0;
  localparam logic [3:0] CTL_RST = 4'h0;
  localparam logic [23:0] BOOT_VECTOR = 24'hFF0000;

  // Timing counts in core cycles
  localparam logic [9:0] POR_HOLD_CYCLES = 10'h200;
  localparam logic [8:0] WAKE_PLL_CYCLES = 9'h1F4;
  localparam logic [8:0] WAKE_CORE_CYCLES = 9'h002;
  localparam logic [8:0] WAKE_PERIPH_CYCLES = 9'h005;

  // Valid boot select codes
  localparam logic [2:0] BOOT_EMI8_LOAD = 3'h1;
  localparam logic [2:0] BOOT_EMI8_EXEC = 3'h2;
  localparam logic [2:0] BOOT_MEM16_EXEC = 3'h3;
  localparam logic [2:0] BOOT_SPI_SMALL = 3'h4;
  localparam logic [2:0] BOOT_SPI_LARGE = 3'h5;

  // Positions inside the synchroniser vector
  localparam int SYNC_W = 6;
  localparam int SY_RESET_N = 0;
  localparam int SY_BYPASS = 1;
  localparam int SY_SUPPLY_LOW = 2;
  localparam int SY_BOOT_LSB = 3;

  typedef enum logic [2:0] {ST_HWRST, ST_BOOT, ST_RUN, ST_SLEEP, ST_WAKE} crb_state_e;
  typedef enum logic [1:0] {LP_IDLE, LP_CORE, LP_CORE_PERIPH, LP_ALL} crb_lp_e;

endpackage

// ### inc/crb_sync_if.sv
// Carrier between the sequencer and its pin synchroniser
`timescale 1ns/1ps
interface crb_sync_if;
  import crb_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ### rtl/crb_sync3.sv
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module crb_sync3
  import crb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  crb_sync_if.sync pins
);

  typedef struct packed {
    logic [SYNC_W-1:0] ff1;
    logic [SYNC_W-1:0] ff2;
    logic [SYNC_W-1:0] ff3;
    logic [SYNC_W-1:0] clean;
  } crb_sync_s;

  crb_sync_s q_r;
  crb_sync_s q_nxt;

  // Only the second flop reads the first; output moves when second and third agree
  always_comb begin
    q_nxt = q_r;
    q_nxt.ff1 = pins.raw;
    q_nxt.ff2 = q_r.ff1;
    q_nxt.ff3 = q_r.ff2;
    q_nxt.clean = (q_r.ff2 & q_r.ff3) | (q_r.clean & (q_r.ff2 ^ q_r.ff3));
  end

  // All zero at reset, so the reset pin reads as asserted
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pins.clean = q_r.clean;

endmodule

// ### rtl/crb_seq.sv
// Clock, reset, power-down and boot sequencer with AHB-Lite registers
`timescale 1ns/1ps
module crb_seq
  import crb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic reset_pin_n_i,
  input wire logic pll_bypass_i,
  input wire logic boot_select_bit2_i,
  input wire logic boot_select_bit1_i,
  input wire logic boot_select_bit0_i,
  input wire logic supply_low_i,
  input wire logic halt_i,
  input wire logic wake_irq_i,
  input wire logic bus_request_i,
  output logic por_reset_n_o,
  output logic master_reset_o,
  output logic irq_mask_all_o,
  output logic core_clock_en_o,
  output logic periph_clk_en_o,
  output logic output_clock_pin_o,
  output logic pll_enable_o,
  output logic pll_bypass_o,
  output logic [6:0] multiplier_select_field_o,
  output logic input_divide_bit_o,
  output logic pipeline_flush_o,
  output logic periph_bus_halt_o,
  output logic core_run_o,
  output logic boot_irq_o,
  output logic [23:0] boot_vector_o,
  output logic exec_resume_o,
  output logic [2:0] boot_mode_o,
  output logic boot_mode_valid_o
);

  typedef struct packed {
    crb_state_e st;
    crb_lp_e lp;
    logic [6:0] mult;
    logic div;
    logic pd;
    logic stop_clock_bit;
    logic stall;
    logic ratio;
    logic ha_valid;
    logic ha_write;
    logic [7:0] ha_addr;
    logic [31:0] rdata;
    logic ready;
    logic [9:0] por_cnt;
    logic por_n;
    logic [2:0] boot_mode;
    logic bypass;
    logic [8:0] wait_cnt;
    logic core_en;
    logic per_en;
    logic pll_en;
    logic flush;
    logic bus_halt;
    logic run;
    logic boot_irq;
    logic resume;
    logic per_phase;
    logic per_tick;
    logic clk_pin;
    logic mrst;
    logic irq_mask;
    logic [23:0] pc;
  } crb_seq_s;

  crb_seq_s q_r;
  crb_seq_s q_nxt;
  logic rst_meta_r;
  logic rst_sync_r;
  logic sw_reset;
  logic hard_reset;
  logic [2:0] boot_pins;

  crb_sync_if pin_if ();

  // Reset asserts at once but leaves on a clock edge, so all state exits together
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= 1'b1;
    end else begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Pins from outside the clock domain
  assign pin_if.raw = {boot_select_bit2_i, boot_select_bit1_i, boot_select_bit0_i,
                       supply_low_i, pll_bypass_i, reset_pin_n_i};

  crb_sync3 u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i (rst_sync_r),
    .pins (pin_if.sync)
  );

  assign hard_reset = ~pin_if.clean[SY_RESET_N];
  assign boot_pins = pin_if.clean[SY_BOOT_LSB +: 3];

  // Register defaults shared by hardware and software reset
  function automatic crb_seq_s load_defaults(input crb_seq_s s);
    crb_seq_s r;
    r = s;
    r.mult = MULT_RST;
    r.div = DIV_RST;
    {r.ratio, r.stall, r.stop_clock_bit, r.pd} = CTL_RST;
    r.mrst = 1'b1;
    r.irq_mask = 1'b1;
    r.run = 1'b0;
    r.core_en = 1'b1;
    r.per_en = 1'b1;
    r.pll_en = 1'b1;
    r.bus_halt = 1'b0;
    r.flush = 1'b1;
    r.lp = LP_IDLE;
    r.wait_cnt = '0;
    return r;
  endfunction

  // Low-power mode picked from the control bits at halt time
  function automatic crb_lp_e decode_lp(input logic pd, input logic stop_clock_bit, input logic stall);
    crb_lp_e m;
    m = LP_IDLE;
    if (pd && stop_clock_bit) begin
      m = LP_ALL;
    end else if (pd && stall) begin
      m = LP_CORE_PERIPH;
    end else if (pd) begin
      m = LP_CORE;
    end
    return m;
  endfunction

  // Wake latency per mode; the PLL must settle after a full stop
  function automatic logic [8:0] wake_cycles(input crb_lp_e m);
    logic [8:0] c;
    c = WAKE_CORE_CYCLES;
    case (m)
      LP_ALL: c = WAKE_PLL_CYCLES;
      LP_CORE_PERIPH: c = WAKE_PERIPH_CYCLES;
      default: c = WAKE_CORE_CYCLES;
    endcase
    return c;
  endfunction

  always_comb begin
    q_nxt = q_r;
    sw_reset = 1'b0;
    q_nxt.flush = 1'b0;
    q_nxt.boot_irq = 1'b0;
    q_nxt.resume = 1'b0;
    q_nxt.mrst = 1'b0;
    q_nxt.ready = 1'b1;

    // Bus data phase: writes land here, one cycle after the address
    if (q_r.ha_valid && q_r.ha_write) begin
      case (q_r.ha_addr)
        ADDR_PLL_CFG: begin
          q_nxt.mult = hwdata_i[CFG_MULT_LSB +: CFG_MULT_W];
          q_nxt.div = hwdata_i[CFG_DIV_BIT];
        end
        ADDR_PLL_CTL: begin
          q_nxt.pd = hwdata_i[CTL_PD_BIT];
          q_nxt.stop_clock_bit = hwdata_i[CTL_STOP_CLOCK_BIT_BIT];
          q_nxt.stall = hwdata_i[CTL_STALL_BIT];
          q_nxt.ratio = hwdata_i[CTL_RATIO_BIT];
        end
        ADDR_SW_RESET: sw_reset = hwdata_i[SWR_BIT];
        default: begin
        end
      endcase
    end

    // Bus address phase capture
    q_nxt.ha_valid = hsel_i & htrans_i[1] & hready_i;
    q_nxt.ha_write = hwrite_i;
    q_nxt.ha_addr = haddr_i[7:0];

    // Power-on reset: low for the hold count after power-up or a supply dip
    if (pin_if.clean[SY_SUPPLY_LOW]) begin
      q_nxt.por_cnt = '0;
      q_nxt.por_n = 1'b0;
    end else if (q_r.por_cnt != POR_HOLD_CYCLES) begin
      q_nxt.por_cnt = q_r.por_cnt + 10'h001;
    end else begin
      q_nxt.por_n = 1'b1;
    end

    // Sequencer
    if (hard_reset) begin
      q_nxt = load_defaults(q_nxt);
      q_nxt.st = ST_HWRST;
      q_nxt.boot_mode = boot_pins;
      q_nxt.bypass = pin_if.clean[SY_BYPASS];
    end else if (sw_reset) begin
      q_nxt = load_defaults(q_nxt);
      q_nxt.st = ST_BOOT;
    end else begin
      case (q_r.st)
        ST_HWRST: begin
          q_nxt.st = ST_BOOT;
        end
        ST_BOOT: begin
          // A pending bus request holds off the jump to boot code
          if (!bus_request_i) begin
            q_nxt.boot_irq = 1'b1;
            q_nxt.pc = BOOT_VECTOR;
            q_nxt.irq_mask = 1'b0;
            q_nxt.run = 1'b1;
            q_nxt.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (halt_i) begin
            q_nxt.lp = decode_lp(q_r.pd, q_r.stop_clock_bit, q_r.stall);
            q_nxt.run = 1'b0;
            q_nxt.core_en = (q_nxt.lp == LP_IDLE);
            if (q_nxt.lp == LP_CORE_PERIPH || q_nxt.lp == LP_ALL) begin
              q_nxt.per_en = 1'b0;
              q_nxt.bus_halt = 1'b1;
              q_nxt.flush = 1'b1;
            end
            q_nxt.pll_en = (q_nxt.lp != LP_ALL);
            q_nxt.st = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_irq_i) begin
            q_nxt.pll_en = 1'b1;
            q_nxt.wait_cnt = wake_cycles(q_r.lp);
            q_nxt.st = ST_WAKE;
          end
        end
        ST_WAKE: begin
          // Clocks stay off until the latency has run out
          if (q_r.wait_cnt <= 9'h001) begin
            q_nxt.wait_cnt = '0;
            q_nxt.core_en = 1'b1;
            q_nxt.per_en = 1'b1;
            q_nxt.bus_halt = 1'b0;
            q_nxt.run = 1'b1;
            q_nxt.resume = 1'b1;
            q_nxt.st = ST_RUN;
          end else begin
            q_nxt.wait_cnt = q_r.wait_cnt - 9'h001;
          end
        end
        default: begin
          q_nxt.st = ST_HWRST;
        end
      endcase
    end

    // Peripheral clock at full or half core rate, mirrored on the pin
    q_nxt.per_phase = ~q_r.per_phase;
    q_nxt.per_tick = q_nxt.per_en & (~q_nxt.ratio | q_r.per_phase);
    if (q_nxt.per_tick) begin
      q_nxt.clk_pin = ~q_r.clk_pin;
    end

    // Read data from next values, so a read right after a write sees it
    q_nxt.rdata = '0;
    if (q_nxt.ha_valid && !hwrite_i) begin
      case (haddr_i[7:0])
        ADDR_PLL_CFG: begin
          q_nxt.rdata[CFG_MULT_LSB +: CFG_MULT_W] = q_nxt.mult;
          q_nxt.rdata[CFG_DIV_BIT] = q_nxt.div;
        end
        ADDR_PLL_CTL: begin
          q_nxt.rdata[CTL_PD_BIT] = q_nxt.pd;
          q_nxt.rdata[CTL_STOP_CLOCK_BIT_BIT] = q_nxt.stop_clock_bit;
          q_nxt.rdata[CTL_STALL_BIT] = q_nxt.stall;
          q_nxt.rdata[CTL_RATIO_BIT] = q_nxt.ratio;
        end
        ADDR_STATUS: begin
          q_nxt.rdata[STAT_MODE_LSB +: 3] = q_r.boot_mode;
          q_nxt.rdata[STAT_VALID_BIT] = boot_mode_valid_o;
          q_nxt.rdata[STAT_LP_LSB +: 2] = q_r.lp;
          q_nxt.rdata[STAT_RUN_BIT] = q_r.run;
          q_nxt.rdata[STAT_BYPASS_BIT] = q_r.bypass;
        end
        default: begin
        end
      endcase
    end
  end

  // State register; defaults mirror a master reset
  always_ff @(posedge sys_clk_i or posedge rst_sync_r) begin
    if (rst_sync_r) begin
      q_r <= '0;
      q_r.st <= ST_HWRST;
      q_r.mult <= MULT_RST;
      q_r.div <= DIV_RST;
      q_r.ready <= 1'b1;
      q_r.core_en <= 1'b1;
      q_r.per_en <= 1'b1;
      q_r.pll_en <= 1'b1;
      q_r.mrst <= 1'b1;
      q_r.irq_mask <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Codes 0, 6 and 7 are reserved; software sees them flagged invalid
  always_ff @(posedge sys_clk_i or posedge rst_sync_r) begin
    if (rst_sync_r) begin
      boot_mode_valid_o <= 1'b0;
    end else begin
      boot_mode_valid_o <= (q_nxt.boot_mode == BOOT_EMI8_LOAD) ||
                           (q_nxt.boot_mode == BOOT_EMI8_EXEC) ||
                           (q_nxt.boot_mode == BOOT_MEM16_EXEC) ||
                           (q_nxt.boot_mode == BOOT_SPI_SMALL) ||
                           (q_nxt.boot_mode == BOOT_SPI_LARGE);
    end
  end

  // Outputs straight from the state register, except hresp_o tied low
  assign hrdata_o = q_r.rdata;
  assign hreadyout_o = q_r.ready;
  assign hresp_o = 1'b0;
  assign por_reset_n_o = q_r.por_n;
  assign master_reset_o = q_r.mrst;
  assign irq_mask_all_o = q_r.irq_mask;
  assign core_clock_en_o = q_r.core_en;
  assign periph_clk_en_o = q_r.per_tick;
  assign output_clock_pin_o = q_r.clk_pin;
  assign pll_enable_o = q_r.pll_en;
  assign pll_bypass_o = q_r.bypass;
  assign multiplier_select_field_o = q_r.mult;
  assign input_divide_bit_o = q_r.div;
  assign pipeline_flush_o = q_r.flush;
  assign periph_bus_halt_o = q_r.bus_halt;
  assign core_run_o = q_r.run;
  assign boot_irq_o = q_r.boot_irq;
  assign boot_vector_o = q_r.pc;
  assign exec_resume_o = q_r.resume;
  assign boot_mode_o = q_r.boot_mode;

endmodule

// ### test/crb_checker.sv
// Port assertions for the clock, reset and boot sequencer
`timescale 1ns/1ps
module crb_checker
  import crb_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic bus_request_i,
  input wire logic supply_low_i,
  input wire logic por_reset_n_o,
  input wire logic master_reset_o,
  input wire logic irq_mask_all_o,
  input wire logic core_clock_en_o,
  input wire logic periph_clk_en_o,
  input wire logic output_clock_pin_o,
  input wire logic pll_enable_o,
  input wire logic [6:0] multiplier_select_field_o,
  input wire logic periph_bus_halt_o,
  input wire logic pipeline_flush_o,
  input wire logic core_run_o,
  input wire logic boot_irq_o,
  input wire logic [23:0] boot_vector_o,
  input wire logic exec_resume_o,
  input wire logic [2:0] boot_mode_o,
  input wire logic boot_mode_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Deep sleep drops everything together
  property p_all_stop;
    $fell(pll_enable_o) |-> !core_clock_en_o && periph_bus_halt_o && !core_run_o;
  endproperty
  a_all_stop: assert property (p_all_stop) else $error("deep sleep left a clock on");
  // PLL restart waits out the full settle time
  localparam logic [9:0] WAKE_SPAN = 10'h1F4;
  logic pll_q_r;
  logic [9:0] wake_cnt_r;
  // Cycles since the PLL came back; counted, since a long delay is slow to unroll
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_q_r <= 1'b1;
      wake_cnt_r <= 10'h000;
    end else begin
      pll_q_r <= pll_enable_o;
      if (pll_enable_o && !pll_q_r && !master_reset_o) begin
        wake_cnt_r <= 10'h001;
      end else if (wake_cnt_r != 10'h000 && wake_cnt_r != WAKE_SPAN) begin
        wake_cnt_r <= wake_cnt_r + 10'h001;
      end else begin
        wake_cnt_r <= 10'h000;
      end
    end
  end
  // Resume exactly at the end of the span, never before
  property p_wake_wait;
    wake_cnt_r != 10'h000 |-> exec_resume_o == (wake_cnt_r == WAKE_SPAN);
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("resume not 500 after wake");
  property p_boot_vec;
    boot_irq_o |-> boot_vector_o == BOOT_VECTOR && core_run_o && !irq_mask_all_o;
  endproperty
  a_boot_vec: assert property (p_boot_vec) else $error("boot start address wrong");
  property p_boot_pulse;
    boot_irq_o |=> !boot_irq_o;
  endproperty
  a_boot_pulse: assert property (p_boot_pulse) else $error("boot interrupt too long");
  property p_boot_hold;
    boot_irq_o |-> !$past(bus_request_i);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot during bus request");
  property p_master;
    master_reset_o |-> irq_mask_all_o && multiplier_select_field_o == MULT_RST;
  endproperty
  a_master: assert property (p_master) else $error("master reset kept state");
  // Pin only moves around a peripheral tick
  property p_output_clock_pin;
    $changed(output_clock_pin_o) |-> periph_clk_en_o || $past(periph_clk_en_o);
  endproperty
  a_output_clock_pin: assert property (p_output_clock_pin) else $error("clock pin moved without tick");
  property p_mode_valid;
    boot_mode_valid_o == (boot_mode_o >= 3'h1 && boot_mode_o <= 3'h5);
  endproperty
  a_mode_valid: assert property (p_mode_valid) else $error("boot code validity wrong");
  // Supply flag crosses the pin synchroniser before the output can drop
  property p_por;
    supply_low_i [*5] |=> !por_reset_n_o;
  endproperty
  a_por: assert property (p_por) else $error("no reset on low supply");
  property p_rst_sync;
    $past(rst_i) |-> master_reset_o [*3];
  endproperty
  a_rst_sync: assert property (p_rst_sync) else $error("reset left too early");
  // Stopping the bus also discards the pipeline
  property p_flush;
    $rose(periph_bus_halt_o) |-> pipeline_flush_o;
  endproperty
  a_flush: assert property (p_flush) else $error("pipeline kept on deep sleep");
  c_boot: cover property (boot_irq_o);
  c_wake: cover property (exec_resume_o);
  c_deep: cover property ($fell(pll_enable_o));
endmodule

// ### test/crb_pins_model.sv
// Far side model: reset source, power monitor and boot straps
`timescale 1ns/1ps
module crb_pins_model #(
  parameter int HOLD = 512
) (
  input wire logic sys_clk_i,
  input wire logic rst_req_i,
  input wire logic [2:0] code_i,
  input wire logic low_i,
  output logic reset_pin_n_o,
  output logic [2:0] boot_o,
  output logic bypass_o,
  output logic supply_low_o
);
  int cnt = 0;
  // Pin low from power-up and on request; release after HOLD cycles
  always @(posedge sys_clk_i) begin
    if (rst_req_i) cnt <= 0;
    else if (cnt < HOLD) cnt <= cnt + 1;
  end
  // Straps and supply monitor follow the bench settings
  assign reset_pin_n_o = (cnt >= HOLD);
  assign boot_o = code_i;
  assign bypass_o = code_i[2] ^ code_i[0];
  assign supply_low_o = low_i;
endmodule

// ### test/testbench.sv
// Self-checking bench for the clock, reset and boot sequencer
`timescale 1ns/1ps
module testbench;
  import crb_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic halt = 1'b0;
  logic wake = 1'b0;
  logic busreq = 1'b0;
  logic rst_req = 1'b0;
  logic low = 1'b0;
  logic [2:0] code = 3'h1;
  logic [31:0] q;
  wire logic [31:0] hrdata;
  wire logic [23:0] vec;
  wire logic [6:0] mult;
  wire logic [2:0] boot, mode;
  wire logic hrdy, pin_n, byp, slow, por_n, core_clock, tick, pll, bhalt, run, birq, res, vld, div, bypo;
  int num_errors = 0;
  int checks_done = 0;
  int boot_cnt = 0;
  crb_seq u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .reset_pin_n_i(pin_n),
    .pll_bypass_i(byp), .boot_select_bit2_i(boot[2]), .boot_select_bit1_i(boot[1]),
    .boot_select_bit0_i(boot[0]), .supply_low_i(slow), .halt_i(halt), .wake_irq_i(wake),
    .bus_request_i(busreq), .por_reset_n_o(por_n), .master_reset_o(), .irq_mask_all_o(),
    .core_clock_en_o(core_clock), .periph_clk_en_o(tick), .output_clock_pin_o(), .pll_enable_o(pll),
    .pll_bypass_o(bypo), .multiplier_select_field_o(mult), .input_divide_bit_o(div),
    .pipeline_flush_o(), .periph_bus_halt_o(bhalt), .core_run_o(run), .boot_irq_o(birq),
    .boot_vector_o(vec), .exec_resume_o(res), .boot_mode_o(mode), .boot_mode_valid_o(vld));
  crb_pins_model u_pins (.sys_clk_i(sys_clk_i), .rst_req_i(rst_req), .code_i(code),
    .low_i(low), .reset_pin_n_o(pin_n), .boot_o(boot), .bypass_o(byp), .supply_low_o(slow));
  // 125 MHz clock
  always #4 sys_clk_i = ~sys_clk_i;
  // Boot interrupt pulses seen so far
  always @(posedge sys_clk_i) if (birq === 1'b1) boot_cnt++;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Single AHB transfer; waits on ready, no fixed latency assumed
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge sys_clk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk_i); while (hrdy !== 1'b1);
    q = hrdata;
  endtask
  task automatic t_boot(input logic [2:0] c);
    @(posedge sys_clk_i);
    code <= c; busreq <= 1'b1; rst_req <= 1'b1;
    @(posedge sys_clk_i) rst_req <= 1'b0;
    boot_cnt = 0;
    // Pin still reads high in this time step; see it drop before waiting for release
    wait (pin_n === 1'b0);
    wait (pin_n === 1'b1);
    repeat (30) @(posedge sys_clk_i);
    chk("boot_held", boot_cnt, 0);
    busreq <= 1'b0;
    repeat (20) @(negedge sys_clk_i);
    chk("boot_cnt", boot_cnt, 1);
    chk("vector", vec, BOOT_VECTOR);
    chk("mode", mode, c);
    chk("valid", vld, c >= 3'h1 && c <= 3'h5);
    chk("bypass", bypo, c[2] ^ c[0]);
    chk("run", run, 1'b1);
    $display("boot code %0d done", c);
  endtask
  task automatic t_regs;
    ahb(ADDR_PLL_CFG, 1'b0, 32'h0);
    chk("cfg_rst", q, {24'h0, DIV_RST, MULT_RST});
    ahb(ADDR_PLL_CFG, 1'b1, 32'h8A); // Fast input clock: divide set
    ahb(ADDR_PLL_CFG, 1'b0, 32'h0);
    chk("cfg", q, 32'h8A);
    chk("mult_pin", {div, mult}, 8'h8A);
    ahb(8'h10, 1'b1, 32'hFF);
    ahb(8'h10, 1'b0, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("registers done");
  endtask
  task automatic t_swrst;
    boot_cnt = 0;
    ahb(ADDR_SW_RESET, 1'b1, 32'h1);
    repeat (20) @(negedge sys_clk_i);
    chk("sw_boot", boot_cnt, 1);
    ahb(ADDR_PLL_CFG, 1'b0, 32'h0);
    chk("sw_cfg", q, {24'h0, DIV_RST, MULT_RST});
    $display("software reset done");
  endtask
  task automatic t_sleep(input logic [31:0] ctl, input int lat);
    int n;
    ahb(ADDR_PLL_CTL, 1'b1, ctl);
    @(posedge sys_clk_i) halt <= 1'b1;
    @(posedge sys_clk_i) halt <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk("sleep_run", run, 1'b0);
    chk("core_clk", core_clock, ctl == 0);
    chk("pll", pll, ctl != 3);
    chk("bus_halt", bhalt, ctl == 3 || ctl == 5);
    @(posedge sys_clk_i) wake <= 1'b1;
    @(posedge sys_clk_i) wake <= 1'b0;
    for (n = 0; n < 600; n++) begin
      @(negedge sys_clk_i);
      if (res === 1'b1) break;
    end
    chk("wake_lat", n, lat);
    $display("sleep mode %0d done", ctl);
  endtask
  task automatic t_ratio(input logic r, input int exp);
    int n;
    ahb(ADDR_PLL_CTL, 1'b1, {28'h0, r, 3'h0}); // Ratio bit set to r; power-down bits written clear
    repeat (3) @(negedge sys_clk_i);
    n = 0;
    repeat (20) @(negedge sys_clk_i) n += int'(tick);
    chk("ticks", n, exp);
    $display("ratio %0d done", r);
  endtask
  task automatic t_por;
    int n;
    @(posedge sys_clk_i) low <= 1'b1;
    repeat (10) @(negedge sys_clk_i);
    chk("por_low", por_n, 1'b0);
    @(posedge sys_clk_i) low <= 1'b0;
    for (n = 0; n < 700 && por_n !== 1'b1; n++) @(negedge sys_clk_i);
    chk("por_wait", n >= 513 && n <= 520, 1'b1);
    $display("power monitor done");
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    wait (pin_n === 1'b1);
    repeat (20) @(posedge sys_clk_i);
    t_regs;
    t_swrst;
    t_ratio(1'b0, 20);
    t_ratio(1'b1, 10);
    t_sleep(32'h0, 2);
    t_sleep(32'h1, 2);
    t_sleep(32'h5, 5);
    t_sleep(32'h3, 500);
    for (int c = 0; c < 8; c++) t_boot(c[2:0]);
    t_por;
    complete_run;
  end
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    num_errors++;
    complete_run;
  end
endmodule
bind crb_seq crb_checker u_chk (.*);
